/* File: rtl/ser_defines.svh */
// Offsets, field positions, reset values and bus constants of the supply enable block
// ==========================================================================
// How it works
// - Enable bit 3 turns the positive gate regulator on; resets to 0.
// - Any source or gate enable also starts the shared step-up converter.
// - Backlight starts only once enabled and bias soft-start has completed.
// - Enable bit 0 picks phase-shift dimming when 1; resets to 1.
// - Phase-shift choice is latched at each backlight start; changes while it runs are ignored.
// - Eight-bit positive source level code, read/write, resets to 0x14.
`ifndef SER_DEFINES_SVH
`define SER_DEFINES_SVH

// ==========================================================================
// Register offsets
`define SER_OFS_ENABLES   8'h02
`define SER_OFS_POS_LEVEL 8'h03

// ==========================================================================
// Enable register field positions
`define SER_BIT_PHASE     0
`define SER_BIT_BLIGHT    1
`define SER_BIT_GVEE      2
`define SER_BIT_GVDD      3
`define SER_BIT_NEG       4
`define SER_BIT_POS       5
`define SER_BIT_BOOST     6

// ==========================================================================
// Reset values
`define SER_RST_ENABLES   7'h01
`define SER_RST_POS_LEVEL 8'h14
`define SER_RD_UNMAPPED   8'h00

// ==========================================================================
// Serial bus constants
`define SER_DEV_ADDR      7'h2A
`define SER_BITS_BYTE     4'h8

`endif

/* File: rtl/ser_pkg.sv */
// Types shared by the supply enable block
package ser_pkg;

   // Control outputs towards the analog supply domains
   typedef struct packed {
      logic boost;      // Main boost converter on
      logic pos;        // Positive source supply on
      logic neg;        // Negative source supply on
      logic gvdd;       // Positive gate regulator on
      logic gvee;       // Negative gate regulator on
      logic step_up;    // Shared step-up converter on
      logic bl_run;     // Backlight converter and sinks running
      logic phase;      // Latched phase-shift dimming choice
   } ser_supply_t;

   // Serial slave states
   typedef enum logic [3:0] {
      SER_IDLE  = 4'b0000,
      SER_ADDR  = 4'b0001,
      SER_ACK_A = 4'b0010,
      SER_PTR   = 4'b0011,
      SER_ACK_P = 4'b0100,
      SER_WDATA = 4'b0101,
      SER_ACK_W = 4'b0110,
      SER_RDATA = 4'b0111,
      SER_RACK  = 4'b1000
   } ser_state_t;

endpackage

/* File: rtl/ser_regs.sv */
// Serial-controlled supply enable and positive source level registers
`timescale 1ns/1ps
`default_nettype none
`include "ser_defines.svh"

module ser_regs #(
   parameter logic [6:0] DEV_ADDR = `SER_DEV_ADDR  // Bus address, value arbitrary
) (
   input  wire logic          clk,          // 250 MHz internal clock
   input  wire logic          rstn,         // Power-on reset, async, active low
   input  wire logic          scl,          // Serial clock pin
   input  wire logic          sda_in,       // Serial data pin level
   output logic               sda_out,      // Serial data drive value
   output logic               sda_oe,       // Serial data pull-low enable
   input  wire logic          ss_done,      // Bias section soft-start complete
   output ser_pkg::ser_supply_t supply,     // Supply domain controls
   output logic [7:0]         pos_level     // Positive source level code
);
   import ser_pkg::*;

   // ======================================================================
   // Pin synchronisers
   logic [1:0] scl_sync;
   logic [1:0] sda_sync;
   logic [1:0] ssd_sync;
   logic       scl_d;
   logic       sda_d;

   // Two flops before any logic sees the pins
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         scl_sync <= 2'h3;
         sda_sync <= 2'h3;
         ssd_sync <= 2'h0;
         scl_d    <= 1'b1;
         sda_d    <= 1'b1;
      end else begin
         scl_sync <= {scl_sync[0], scl};
         sda_sync <= {sda_sync[0], sda_in};
         ssd_sync <= {ssd_sync[0], ss_done};
         scl_d    <= scl_sync[1];
         sda_d    <= sda_sync[1];
      end
   end

   wire scl_s    = scl_sync[1];
   wire sda_s    = sda_sync[1];
   wire ss_s     = ssd_sync[1];
   wire scl_rise = scl_s & ~scl_d;
   wire scl_fall = ~scl_s & scl_d;
   wire bus_start = scl_s & scl_d & sda_d & ~sda_s;
   wire bus_stop  = scl_s & scl_d & ~sda_d & sda_s;

   // ======================================================================
   // Register storage and read decode
   logic [6:0] enables;
   logic       reg_we;
   logic [7:0] reg_addr;
   logic [7:0] reg_wdata;

   // Read value of any offset; bit 7 of enables is always zero
   function automatic logic [7:0] rd_reg(input logic [7:0] a, input logic [6:0] en,
                                         input logic [7:0] lvl);
      case (a)
         `SER_OFS_ENABLES:   rd_reg = {1'b0, en};
         `SER_OFS_POS_LEVEL: rd_reg = lvl;
         default:            rd_reg = `SER_RD_UNMAPPED;
      endcase
   endfunction

   // Enable register write; bit 7 of the written byte is dropped
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         enables <= `SER_RST_ENABLES;
      end else if (reg_we && reg_addr == `SER_OFS_ENABLES) begin
         enables <= reg_wdata[6:0];
      end
   end

   // Positive source level code
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         pos_level <= `SER_RST_POS_LEVEL;
      end else if (reg_we && reg_addr == `SER_OFS_POS_LEVEL) begin
         pos_level <= reg_wdata;
      end
   end

   // ======================================================================
   // Supply controls
   wire any_rail = enables[`SER_BIT_POS] | enables[`SER_BIT_NEG] |
                   enables[`SER_BIT_GVDD] | enables[`SER_BIT_GVEE];
   wire bl_go    = enables[`SER_BIT_BLIGHT] & ss_s;

   // Rail enables, step-up pull-in and backlight start gating
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         supply <= '0;
      end else begin
         supply.boost   <= enables[`SER_BIT_BOOST];
         supply.pos     <= enables[`SER_BIT_POS];
         supply.neg     <= enables[`SER_BIT_NEG];
         supply.gvdd    <= enables[`SER_BIT_GVDD];
         supply.gvee    <= enables[`SER_BIT_GVEE];
         supply.step_up <= enables[`SER_BIT_BOOST] | any_rail;
         supply.bl_run  <= bl_go;
         if (bl_go && !supply.bl_run) begin
            supply.phase <= enables[`SER_BIT_PHASE];
         end
      end
   end

   // ======================================================================
   // Serial slave
   ser_state_t state;
   logic [3:0] cnt;
   logic [7:0] shreg;
   logic [7:0] ptr;
   logic       rnw;
   logic       nack;
   logic [7:0] rd_val;

   assign sda_out  = 1'b0;   // Open drain: only ever pulls low
   assign reg_addr = ptr;
   // Byte that the next read slot will send, taken whole at its first bit
   assign rd_val   = rd_reg(ptr, enables, pos_level);

   // Byte collection, acknowledge, pointer and read shifting
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state     <= SER_IDLE;
         cnt       <= 4'h0;
         shreg     <= 8'h00;
         ptr       <= 8'h00;
         rnw       <= 1'b0;
         nack      <= 1'b0;
         sda_oe    <= 1'b0;
         reg_we    <= 1'b0;
         reg_wdata <= 8'h00;
      end else begin
         reg_we <= 1'b0;
         if (bus_start) begin
            state  <= SER_ADDR;
            cnt    <= 4'h0;
            sda_oe <= 1'b0;
         end else if (bus_stop) begin
            state  <= SER_IDLE;
            sda_oe <= 1'b0;
         end else begin
            case (state)
               SER_ADDR, SER_PTR, SER_WDATA: begin
                  if (scl_rise && cnt != `SER_BITS_BYTE) begin
                     shreg <= {shreg[6:0], sda_s};
                     cnt   <= cnt + 4'h1;
                  end else if (scl_fall && cnt == `SER_BITS_BYTE) begin
                     cnt <= 4'h0;
                     if (state == SER_ADDR) begin
                        if (shreg[7:1] == DEV_ADDR) begin
                           rnw    <= shreg[0];
                           sda_oe <= 1'b1;
                           state  <= SER_ACK_A;
                        end else begin
                           state <= SER_IDLE;
                        end
                     end else if (state == SER_PTR) begin
                        ptr    <= shreg;
                        sda_oe <= 1'b1;
                        state  <= SER_ACK_P;
                     end else begin
                        reg_we    <= 1'b1;
                        reg_wdata <= shreg;
                        sda_oe    <= 1'b1;
                        state     <= SER_ACK_W;
                     end
                  end
               end
               SER_ACK_A: begin
                  if (scl_fall) begin
                     if (rnw) begin
                        shreg  <= rd_val;
                        sda_oe <= ~rd_val[7];
                        cnt    <= 4'h1;
                        state  <= SER_RDATA;
                     end else begin
                        sda_oe <= 1'b0;
                        state  <= SER_PTR;
                     end
                  end
               end
               SER_ACK_P: begin
                  if (scl_fall) begin
                     sda_oe <= 1'b0;
                     state  <= SER_WDATA;
                  end
               end
               SER_ACK_W: begin
                  if (scl_fall) begin
                     sda_oe <= 1'b0;
                     ptr    <= ptr + 8'h01;   // Auto-increment after each write
                     state  <= SER_WDATA;
                  end
               end
               SER_RDATA: begin
                  if (scl_fall) begin
                     if (cnt == `SER_BITS_BYTE) begin
                        sda_oe <= 1'b0;
                        ptr    <= ptr + 8'h01;
                        state  <= SER_RACK;
                     end else begin
                        shreg  <= {shreg[6:0], 1'b0};
                        sda_oe <= ~shreg[6];
                        cnt    <= cnt + 4'h1;
                     end
                  end
               end
               SER_RACK: begin
                  if (scl_rise) begin
                     nack <= sda_s;
                  end else if (scl_fall) begin
                     if (nack) begin
                        state <= SER_IDLE;
                     end else begin
                        shreg  <= rd_val;
                        sda_oe <= ~rd_val[7];
                        cnt    <= 4'h1;
                        state  <= SER_RDATA;
                     end
                  end
               end
               default: begin
                  sda_oe <= 1'b0;
                  state  <= SER_IDLE;
               end
            endcase
         end
      end
   end

   // ======================================================================
   // Assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   property p_gvdd_write;
      reg_we && reg_addr == `SER_OFS_ENABLES |=> ##1 supply.gvdd == $past(reg_wdata[3], 2);
   endproperty
   a_gvdd_write: assert property (p_gvdd_write) else $error("gvdd enable not written");

   property p_step_up;
      (enables[`SER_BIT_POS] | enables[`SER_BIT_NEG] | enables[`SER_BIT_GVDD]
       | enables[`SER_BIT_GVEE]) |=> supply.step_up;
   endproperty
   a_step_up: assert property (p_step_up) else $error("step-up not pulled in");

   property p_bl_gate;
      $rose(supply.bl_run) |-> $past(ss_s) && $past(enables[`SER_BIT_BLIGHT]);
   endproperty
   a_bl_gate: assert property (p_bl_gate) else $error("backlight before soft-start");

   property p_phase_write;
      reg_we && reg_addr == `SER_OFS_ENABLES |=> enables[0] == $past(reg_wdata[0]);
   endproperty
   a_phase_write: assert property (p_phase_write) else $error("phase bit not written");

   property p_phase_hold;
      supply.bl_run && $past(supply.bl_run) |-> $stable(supply.phase);
   endproperty
   a_phase_hold: assert property (p_phase_hold) else $error("phase changed while running");

   property p_level_write;
      reg_we && reg_addr == `SER_OFS_POS_LEVEL |=> pos_level == $past(reg_wdata);
   endproperty
   a_level_write: assert property (p_level_write) else $error("level not written");

   property p_boost_write;
      reg_we && reg_addr == `SER_OFS_ENABLES |=> ##1 supply.boost == $past(reg_wdata[6], 2);
   endproperty
   a_boost_write: assert property (p_boost_write) else $error("boost enable not written");

   // First read bit of the enable register must pull the data line low
   property p_bit7_zero;
      state == SER_RDATA && cnt == 4'h1 && ptr == `SER_OFS_ENABLES |-> sda_oe;
   endproperty
   a_bit7_zero: assert property (p_bit7_zero) else $error("enable bit 7 reads one");

endmodule // ser_regs
`default_nettype wire

/* File: test/ser_host.sv */
// Serial bus host model that reaches the supply enable registers
`timescale 1ns/1ps
`default_nettype none

module ser_host (
   input  wire logic clk,      // Bench clock, host moves on its falling edge
   input  wire logic sda_wire, // Resolved data wire level
   output logic      scl,      // Serial clock drive
   output logic      pull_low  // High while the host pulls data low
);
   // ==========================================================================
   // Line levels: both lines idle high
   initial begin
      scl = 1'b1;
      pull_low = 1'b0;
   end

   // One bus phase of ten clocks, above the three the slave needs
   task automatic half();
      repeat (10) @(negedge clk);
   endtask

   // Start or repeated start, leaving the clock low
   task automatic start();
      pull_low = 1'b0;
      half();
      scl = 1'b1;
      half();
      pull_low = 1'b1;
      half();
      scl = 1'b0;
      half();
   endtask

   // Stop: data rises while the clock is high, then the bus idles
   task automatic stop();
      pull_low = 1'b1;
      half();
      scl = 1'b1;
      half();
      pull_low = 1'b0;
      half();
   endtask

   // One bit: data set while clock low, sampled at the end of the high phase
   task automatic bit_io(input logic b, output logic s);
      pull_low = ~b;
      half();
      scl = 1'b1;
      half();
      s = sda_wire;
      scl = 1'b0;
      half();
   endtask

   // One byte MSB first, then the acknowledge slot
   task automatic xfer(input logic [7:0] tx, input logic ack_in,
                       output logic [7:0] rx, output logic ack_out);
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], rx[i]);
      end
      bit_io(ack_in, ack_out);
   endtask

   // Pointer write followed by one data byte
   task automatic write_reg(input logic [6:0] dev, input logic [7:0] ofs,
                            input logic [7:0] data, output logic [2:0] ack);
      logic [7:0] rx;
      start();
      xfer({dev, 1'b0}, 1'b1, rx, ack[2]);
      xfer(ofs, 1'b1, rx, ack[1]);
      xfer(data, 1'b1, rx, ack[0]);
      stop();
   endtask

   // Pointer write, repeated start, one byte read and closed with a NACK
   task automatic read_reg(input logic [6:0] dev, input logic [7:0] ofs,
                           output logic [7:0] data, output logic [2:0] ack);
      logic [7:0] rx;
      logic       nack;
      start();
      xfer({dev, 1'b0}, 1'b1, rx, ack[2]);
      xfer(ofs, 1'b1, rx, ack[1]);
      start();
      xfer({dev, 1'b1}, 1'b1, rx, ack[0]);
      xfer(8'hFF, 1'b1, data, nack);
      stop();
   endtask
endmodule // ser_host

`default_nettype wire

/* File: test/tb_top.sv */
// Self-checking bench for the supply enable and level registers
`timescale 1ns/1ps
`default_nettype none

module tb_top;
   import ser_pkg::*;
   localparam logic [6:0] DEV = 7'h2A; // Bus address, value arbitrary

   logic                clk, rstn, scl, sda_out, sda_oe, ss_done, pull_low, sda_wire;
   ser_pkg::ser_supply_t supply;
   logic [7:0]          pos_level;
   int                  err_count, check_count;
   int                  bits [5] = '{3, 5, 4, 2, 6}; // Enable positions walked singly

   // ==========================================================================
   // Open-drain data wire with pull-up; the device pulls low only when it drives a 0
   assign sda_wire = ~((sda_oe & ~sda_out) | pull_low);

   ser_regs #(.DEV_ADDR(DEV)) ser_regs_inst (.clk(clk), .rstn(rstn), .scl(scl),
      .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe), .ss_done(ss_done),
      .supply(supply), .pos_level(pos_level));
   ser_host ser_host_inst (.clk(clk), .sda_wire(sda_wire), .scl(scl), .pull_low(pull_low));

   // 250 MHz clock
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // ==========================================================================
   // Compare, bus and report helpers
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         $display("Error %s expected %h seen %h", what, exp, got);
         err_count++;
      end
   endtask

   task automatic wr(input logic [7:0] ofs, input logic [7:0] data);
      logic [2:0] a;
      ser_host_inst.write_reg(DEV, ofs, data, a);
      chk("write ack", 8'h00, {5'h00, a});
   endtask

   task automatic rd(input logic [7:0] ofs, input logic [7:0] exp);
      logic [2:0] a;
      logic [7:0] d;
      ser_host_inst.read_reg(DEV, ofs, d, a);
      chk("read ack", 8'h00, {5'h00, a});
      chk("read data", exp, d);
   endtask

   // Expected supply controls from enable bits, backlight state and latched phase
   function automatic logic [7:0] expsup(logic [7:0] en, logic bl, logic ph);
      return {en[6], en[5], en[4], en[3], en[2], |en[6:2], bl, ph};
   endfunction

   task automatic sup(input logic [7:0] exp);
      @(negedge clk);
      chk("supply", exp, supply);
   endtask

   // Bounded wait for the backlight run state
   task automatic wait_bl(input logic v);
      int n;
      for (n = 0; n < 20 && supply.bl_run !== v; n++) begin
         @(negedge clk);
      end
      if (n == 20) begin
         $display("Error backlight wait expected %b seen %b", v, supply.bl_run);
         err_count++;
         conclude();
      end
   endtask

   task automatic conclude();
      $display("Checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // ==========================================================================
   // Main sequence
   initial begin
      logic [2:0] a;
      err_count = 0;
      check_count = 0;
      rstn = 1'b0;
      ss_done = 1'b0;
      repeat (6) @(negedge clk);
      rstn = 1'b1;
      repeat (3) @(negedge clk);
      chk("supply reset", 8'h00, supply);
      chk("level reset", 8'h14, pos_level);
      rd(8'h02, 8'h01);
      rd(8'h03, 8'h14);
      // Each rail alone, step-up follows
      foreach (bits[i]) begin
         wr(8'h02, 8'h01 << bits[i]);
         sup(expsup(8'h01 << bits[i], 1'b0, 1'b0));
      end
      wr(8'h02, 8'h00);
      sup(8'h00);
      // Backlight held until soft-start completes, bit 7 dropped
      wr(8'h02, 8'hFF);
      rd(8'h02, 8'h7F);
      sup(expsup(8'h7F, 1'b0, 1'b0));
      ss_done = 1'b1;
      wait_bl(1'b1);
      sup(expsup(8'h7F, 1'b1, 1'b1));
      // Phase choice frozen while running, resampled at next start
      wr(8'h02, 8'h7E);
      sup(expsup(8'h7E, 1'b1, 1'b1));
      wr(8'h02, 8'h7C);
      sup(expsup(8'h7C, 1'b0, 1'b1));
      wr(8'h02, 8'h7E);
      wait_bl(1'b1);
      sup(expsup(8'h7E, 1'b1, 1'b0));
      ss_done = 1'b0;
      wait_bl(1'b0);
      sup(expsup(8'h7E, 1'b0, 1'b0));
      // Level code mid value and upper end 0xFF, then an unmapped offset
      wr(8'h03, 8'h0A);
      rd(8'h03, 8'h0A);
      chk("level port", 8'h0A, pos_level);
      wr(8'h03, 8'hFF);
      rd(8'h03, 8'hFF);
      rd(8'h05, 8'h00);
      // Foreign address is ignored throughout
      ser_host_inst.write_reg(DEV ^ 7'h01, 8'h02, 8'h00, a);
      chk("foreign ack", 8'h07, {5'h00, a});
      rd(8'h02, 8'h7E);
      // Reset in mid-run brings every register back from non-default values
      rstn = 1'b0;
      repeat (2) @(negedge clk);
      rstn = 1'b1;
      repeat (3) @(negedge clk);
      chk("supply reset", 8'h00, supply);
      chk("level reset", 8'h14, pos_level);
      rd(8'h02, 8'h01);
      rd(8'h03, 8'h14);
      conclude();
   end
endmodule // tb_top

`default_nettype wire
